// ==== rtl/mlg_pkg.sv ====
package mlg_pkg;

  // clock and documented times
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MUTE_MAX_S    = 30;
  localparam int unsigned LAMP_BLANK_MS = 100;
  localparam int unsigned SIMUL_S       = 3;

  // derived cycle counts (defaults of the top-level parameters)
  localparam int unsigned MUTE_MAX_CYC  = MUTE_MAX_S * CLK_HZ;
  localparam int unsigned LAMP_BLANK_CYC = LAMP_BLANK_MS * (CLK_HZ / 1000);
  localparam int unsigned SIMUL_CYC     = SIMUL_S * CLK_HZ;

  // test pulse pattern on the two guard channels, in cycles
  localparam logic [7:0]  TP_LOW        = 8'h08;
  localparam logic [7:0]  TP_B_START    = 8'h80;
  localparam logic [7:0]  TP_SETTLE     = 8'h04;

  // settle time before an off output is read back
  localparam logic [31:0] RB_SETTLE     = 32'h0000_0004;

  typedef struct packed {
    logic guard_channel_one;
    logic guard_channel_two;
    logic muting_sensor_first_a;
    logic muting_sensor_first_b;
    logic muting_sensor_second_a;
    logic muting_sensor_second_b;
    logic continue_run_input;
    logic motor_start_input;
    logic contactor_feedback_input;
    logic lamp_monitor_input_a;
    logic lamp_monitor_input_b;
    logic readback_one;
    logic readback_two;
  } mlg_pins_t;

  typedef struct packed {
    logic guard_short;
    logic overridden;
    logic lamp_defect;
    logic lamp_stuck;
    logic output_short;
  } mlg_fault_t;

  typedef enum logic [2:0] {
    MLG_NORMAL  = 3'b001,
    MLG_MUTING  = 3'b010,
    MLG_EXPIRED = 3'b100
  } mlg_mute_t;

endpackage

// ==== rtl/mlg_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module mlg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,  // system clock
  input  wire logic         i_rst,  // synchronous reset, active high
  input  wire logic [W-1:0] i_d,    // asynchronous pin levels
  output logic      [W-1:0] o_q     // synchronised levels
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // pins reset to zero: a dark guard and open loops are the safe reading
  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/mlg_guard_ctrl.sv ====
// Behaviour
// - drive enabled only while guard clear or muting active; motor then started by start input
// - motor stays enabled during muting although the beam is broken
// - a 30 s maximum muting timer starts when muting begins
// - on timer expiry the motor enable is withdrawn
// - continue-run button restarts muting for a further 30 s
// - muting lamp lights as soon as muting becomes active
// - low on either lamp monitor input is a lamp fault; motor stops
// - lamp monitor faults ignored for 100 ms after lamp switch-on
// - no automatic start: drive starts only on a rising edge of the start input with the feedback loop closed
// - overridden contact found at next actuation; safety outputs go low
// - guard channel cross-short or short to supply is a fault; outputs low
// - lamp monitor input shorted to supply found at next lamp actuation
// - safety output shorted to supply is detected; outputs go low
// - contacts of each muting pair must agree within 3 s
`timescale 1ns/1ps
`default_nettype none

module mlg_guard_ctrl
  import mlg_pkg::*;
#(
  parameter int unsigned MUTE_CYC  = mlg_pkg::MUTE_MAX_CYC,
  parameter int unsigned LAMP_CYC  = mlg_pkg::LAMP_BLANK_CYC,
  parameter int unsigned SIMUL_CYC = mlg_pkg::SIMUL_CYC
) (
  input  wire logic               i_clk,              // 40 MHz clock
  input  wire logic               i_rst,              // synchronous reset, active high
  input  wire mlg_pkg::mlg_pins_t i_pins,             // field inputs, asynchronous
  output logic                    o_motor_safety_one, // motor contactor one drive
  output logic                    o_motor_safety_two, // motor contactor two drive
  output logic                    o_test_pulse_a,     // test pulse feeding guard channel one
  output logic                    o_test_pulse_b,     // test pulse feeding guard channel two
  output logic                    o_muting_lamp,      // muting indicator lamp
  output logic                    o_motor_enable,     // motor-enable point
  output logic                    o_muting_active,    // muting-active point
  output mlg_pkg::mlg_fault_t     o_fault             // latched fault causes
);
  import mlg_pkg::*;

  function automatic logic [31:0] sat_inc(input logic [31:0] c, input logic run);
    sat_inc = !run ? 32'h0 : (c == 32'hFFFF_FFFF) ? c : c + 32'h1;
  endfunction

  mlg_pins_t  p;
  mlg_mute_t  state, next_state;
  mlg_fault_t fault, next_fault, live;
  logic [7:0]  phase, next_phase;
  logic [31:0] mute_cnt, next_mute_cnt, lamp_cnt, next_lamp_cnt;
  logic [31:0] off_cnt, next_off_cnt;
  logic [31:0] sim_cnt [3];
  logic [31:0] next_sim_cnt [3];
  logic guard_clear, next_guard_clear;
  logic [1:0] dip, next_dip;
  logic stuck_pend, next_stuck_pend;
  logic guard_bad, next_guard_bad, guard_ok;
  logic [4:0] gone;
  logic cont_prev, start_prev, next_run, next_lamp;
  logic req1, req2, any_req, none_req, cont_rise, start_rise;
  logic quiet, a_end, b_end, a_back, b_back, start_ok, fault_any, enable;
  logic [2:0] mismatch;

  mlg_sync #(.W($bits(mlg_pins_t))) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_pins),
    .o_q   (p)
  );

  // pattern and sample points of the guard test pulses
  always_comb begin
    next_phase = phase + 8'h01;
    a_end      = (phase == TP_LOW - 8'h01);
    b_end      = (phase == TP_B_START + TP_LOW - 8'h01);
    a_back     = (phase == TP_LOW + TP_SETTLE);
    b_back     = (phase == TP_B_START + TP_LOW + TP_SETTLE);
    quiet      = (phase >= TP_LOW + TP_SETTLE && phase < TP_B_START)
              || (phase >= TP_B_START + TP_LOW + TP_SETTLE);
  end

  always_comb begin
    req1       = p.muting_sensor_first_a & p.muting_sensor_first_b;
    req2       = p.muting_sensor_second_a & p.muting_sensor_second_b;
    any_req    = req1 | req2;
    none_req   = ~(p.muting_sensor_first_a | p.muting_sensor_first_b
                 | p.muting_sensor_second_a | p.muting_sensor_second_b);
    cont_rise  = p.continue_run_input & ~cont_prev;
    start_rise = p.motor_start_input & ~start_prev;
    mismatch   = {quiet & (p.guard_channel_one ^ p.guard_channel_two),
                  p.muting_sensor_second_a ^ p.muting_sensor_second_b,
                  p.muting_sensor_first_a ^ p.muting_sensor_first_b};
    for (int i = 0; i < 3; i++) begin
      next_sim_cnt[i] = sat_inc(sim_cnt[i], mismatch[i]);
    end
  end

  // guard state and short detection: a channel must follow its own pulse only
  always_comb begin
    next_guard_clear = guard_clear;
    next_dip         = dip;
    live.guard_short = 1'b0;
    if (quiet) begin
      next_guard_clear = p.guard_channel_one & p.guard_channel_two;
    end
    if (a_end) begin
      live.guard_short = p.guard_channel_one;
      next_dip[0]      = guard_clear & ~p.guard_channel_two;
    end
    if (b_end) begin
      live.guard_short = p.guard_channel_two;
      next_dip[1]      = guard_clear & ~p.guard_channel_one;
    end
    // the other channel dipped with this pulse and came back: cross-short
    if (a_back) begin
      live.guard_short = dip[0] & p.guard_channel_two;
      next_dip[0]      = 1'b0;
    end
    if (b_back) begin
      live.guard_short = dip[1] & p.guard_channel_one;
      next_dip[1]      = 1'b0;
    end
    // a short is only seen at pulse checks, so it counts as gone after one clean round
    next_guard_bad = (phase == 8'hFF) ? 1'b0 : (guard_bad | live.guard_short);
    guard_ok       = (phase == 8'hFF) && !guard_bad;
  end

  // muting sequence
  always_comb begin
    next_state = state;
    unique case (state)
      MLG_NORMAL: begin
        if (req1 && guard_clear) begin
          next_state = MLG_MUTING;
        end
      end
      MLG_MUTING: begin
        if (mute_cnt >= MUTE_CYC - 1) begin
          next_state = MLG_EXPIRED;
        end else if (!any_req) begin
          next_state = MLG_NORMAL;
        end
      end
      MLG_EXPIRED: begin
        if (cont_rise && any_req) begin
          next_state = MLG_MUTING;
        end else if (none_req) begin
          next_state = MLG_NORMAL;
        end
      end
      default: next_state = MLG_NORMAL;
    endcase
    // counter is zero on entry, also after a continue-run restart
    next_mute_cnt = sat_inc(mute_cnt, state == MLG_MUTING);
  end

  // lamp supervision
  always_comb begin
    next_lamp        = (next_state == MLG_MUTING);
    next_lamp_cnt    = sat_inc(lamp_cnt, next_lamp == o_muting_lamp);
    next_stuck_pend  = stuck_pend;
    live.lamp_defect = o_muting_lamp && lamp_cnt >= LAMP_CYC
                    && !(p.lamp_monitor_input_a && p.lamp_monitor_input_b);
    live.lamp_stuck  = 1'b0;
    if (!o_muting_lamp && lamp_cnt >= LAMP_CYC) begin
      next_stuck_pend = p.lamp_monitor_input_a | p.lamp_monitor_input_b;
    end
    // a monitor input shorted high only shows once the lamp is switched again
    if (next_lamp && !o_muting_lamp) begin
      live.lamp_stuck = stuck_pend;
      next_stuck_pend = 1'b0;
    end
  end

  // outputs, feedback and fault latching
  always_comb begin
    next_off_cnt      = sat_inc(off_cnt, !o_motor_safety_one && !o_motor_safety_two);
    live.output_short = off_cnt >= RB_SETTLE
                     && (p.readback_one || p.readback_two);
    live.overridden   = (sim_cnt[0] >= SIMUL_CYC) || (sim_cnt[1] >= SIMUL_CYC)
                     || (sim_cnt[2] >= SIMUL_CYC)
                     || (start_rise && !o_motor_safety_one
                         && !p.contactor_feedback_input);
    start_ok = guard_clear && p.contactor_feedback_input && none_req;
    gone = {guard_ok, 4'hF};
    for (int i = 0; i < $bits(mlg_fault_t); i++) begin
      // a fresh fault wins over the clear in the same cycle
      next_fault[i] = live[i] | (fault[i] & ~(start_ok & gone[i]));
    end
    fault_any = |next_fault;
    enable    = !fault_any && state != MLG_EXPIRED
             && (guard_clear || next_state == MLG_MUTING);
    // motor latch drops with the enable; restart needs closed feedback
    next_run  = enable && (o_motor_safety_one
             || (start_rise && p.contactor_feedback_input));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state              <= MLG_NORMAL;
      fault              <= '0;
      // first edge after release lands on phase 0, giving a full-width first pulse
      phase              <= 8'hFF;
      mute_cnt           <= 32'h0;
      lamp_cnt           <= 32'h0;
      off_cnt            <= 32'h0;
      sim_cnt            <= '{default: 32'h0};
      guard_clear        <= 1'b0;
      dip                <= 2'b00;
      guard_bad          <= 1'b0;
      stuck_pend         <= 1'b0;
      cont_prev          <= 1'b0;
      start_prev         <= 1'b0;
      o_motor_safety_one <= 1'b0;
      o_motor_safety_two <= 1'b0;
      o_test_pulse_a     <= 1'b1;
      o_test_pulse_b     <= 1'b1;
      o_muting_lamp      <= 1'b0;
      o_motor_enable     <= 1'b0;
      o_muting_active    <= 1'b0;
      o_fault            <= '0;
    end else begin
      state              <= next_state;
      fault              <= next_fault;
      phase              <= next_phase;
      mute_cnt           <= next_mute_cnt;
      lamp_cnt           <= next_lamp_cnt;
      off_cnt            <= next_off_cnt;
      sim_cnt            <= next_sim_cnt;
      guard_clear        <= next_guard_clear;
      dip                <= next_dip;
      guard_bad          <= next_guard_bad;
      stuck_pend         <= next_stuck_pend;
      cont_prev          <= p.continue_run_input;
      start_prev         <= p.motor_start_input;
      o_motor_safety_one <= next_run;
      o_motor_safety_two <= next_run;
      o_test_pulse_a     <= !(next_phase < TP_LOW);
      o_test_pulse_b     <= !(next_phase >= TP_B_START && next_phase < TP_B_START + TP_LOW);
      o_muting_lamp      <= next_lamp;
      o_motor_enable     <= enable;
      o_muting_active    <= next_state == MLG_MUTING;
      o_fault            <= next_fault;
    end
  end

endmodule

`default_nettype wire

// ==== dv/mlg_guard_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module mlg_guard_ctrl_asserts #(
  parameter int unsigned MUTE_CYC = 200
) (
  input wire logic               i_clk,              // clock
  input wire logic               i_rst,              // sync reset
  input wire mlg_pkg::mlg_pins_t i_pins,             // field pins
  input wire logic               o_motor_safety_one, // drive one
  input wire logic               o_motor_safety_two, // drive two
  input wire logic               o_test_pulse_a,     // pulse a
  input wire logic               o_test_pulse_b,     // pulse b
  input wire logic               o_muting_lamp,      // lamp
  input wire logic               o_motor_enable,     // enable point
  input wire logic               o_muting_active,    // muting point
  input wire mlg_pkg::mlg_fault_t o_fault            // faults
);
  import mlg_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int unsigned mute_cnt;
  int unsigned next_mute_cnt;
  always_comb next_mute_cnt = o_muting_active ? mute_cnt + 1 : 0;
  always_ff @(posedge i_clk) mute_cnt <= i_rst ? 0 : next_mute_cnt;
  sequence s_pulse_window;
    !o_test_pulse_a [*8] ##1 o_test_pulse_a;
  endsequence
  sequence s_start_seen;
    $past(i_pins.motor_start_input, 2) || $past(i_pins.motor_start_input, 3);
  endsequence
  a_pair_equal: assert property (o_motor_safety_one == o_motor_safety_two)
    else $error("safety outputs differ");
  a_lamp_follows: assert property (o_muting_lamp == o_muting_active)
    else $error("lamp differs from muting point");
  a_drop_on_disable: assert property ($fell(o_motor_enable) |-> ##[0:2] !o_motor_safety_one)
    else $error("drive kept after enable loss");
  a_mute_keeps: assert property (o_muting_active && $past(o_muting_active) && o_fault == '0
    && $past(o_fault) == '0 |-> o_motor_enable) else $error("enable lost while muted");
  a_mute_bound: assert property (o_muting_active |-> mute_cnt <= MUTE_CYC)
    else $error("muting outlasts its period");
  a_fault_low: assert property ((o_fault != '0) [*3] |-> !o_motor_safety_one)
    else $error("drive on with fault");
  a_fault_holds: assert property (o_fault != '0 && !o_motor_safety_one |=> !o_motor_safety_one)
    else $error("drive restarted with fault");
  a_start_edge: assert property ($rose(o_motor_safety_one) |-> $past(o_motor_enable) ##0 s_start_seen)
    else $error("drive started without start");
  a_pulse_width: assert property ($fell(o_test_pulse_a) |-> s_pulse_window)
    else $error("test pulse window wrong");
endmodule
bind mlg_guard_ctrl mlg_guard_ctrl_asserts #(.MUTE_CYC(MUTE_CYC)) u_mlg_guard_ctrl_asserts (
  .i_clk(i_clk), .i_rst(i_rst), .i_pins(i_pins), .o_motor_safety_one(o_motor_safety_one),
  .o_motor_safety_two(o_motor_safety_two), .o_test_pulse_a(o_test_pulse_a),
  .o_test_pulse_b(o_test_pulse_b), .o_muting_lamp(o_muting_lamp),
  .o_motor_enable(o_motor_enable), .o_muting_active(o_muting_active), .o_fault(o_fault));
`default_nettype wire

// ==== dv/mlg_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mlg_field_model (
  input  wire logic         i_pulse_a, // guard test pulse a
  input  wire logic         i_pulse_b, // guard test pulse b
  input  wire logic         i_out_one, // contactor one drive
  input  wire logic         i_out_two, // contactor two drive
  input  wire logic         i_lamp,    // lamp drive
  input  wire logic         i_beam,    // beam clear
  input  wire logic [3:0]   i_sensors, // actuated sensors, first pair on top
  input  wire logic         i_start,   // start button
  input  wire logic         i_cont,    // continue-run button
  input  wire logic         i_lamp_ok, // low models a dead lamp
  input  wire logic [2:0]   i_mode,    // injected wiring fault
  output mlg_pkg::mlg_pins_t o_pins    // levels at the block
);
  import mlg_pkg::*;
  logic ch_one;
  logic ch_two;
  // modes: 1/2 channel to supply, 3 cross-short, 4 channel two open,
  // 5 readback to supply, 6 lamp monitors to supply
  always_comb begin
    ch_one = i_pulse_a & i_beam;
    ch_two = i_pulse_b & i_beam;
    case (i_mode)
      3'h1: ch_one = 1'b1;
      3'h2: ch_two = 1'b1;
      3'h3: begin
        ch_one = i_pulse_a & i_pulse_b & i_beam;
        ch_two = ch_one;
      end
      3'h4: ch_two = 1'b0;
      default: ;
    endcase
    o_pins = {ch_one, ch_two, i_sensors, i_cont, i_start,
      ~i_out_one & ~i_out_two,
      {2{(i_lamp & i_lamp_ok) | (i_mode == 3'h6)}},
      i_out_one | (i_mode == 3'h5), i_out_two};
  end
endmodule
`default_nettype wire

// ==== dv/tb_mlg_guard_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_mlg_guard_ctrl;
  import mlg_pkg::*;
  localparam int unsigned MUTE = 200;
  logic       i_clk, i_rst, beam, start, cont, lamp_ok;
  logic       s_one, s_two, pa, pb, lamp, en, act;
  logic [3:0] sens;
  logic [2:0] mode;
  mlg_pins_t  pins;
  mlg_fault_t fault;
  int         mismatches;
  int         num_checks;
  int         exp_fault[7] = '{0, 16, 16, 16, 8, 1, 2};
  mlg_guard_ctrl #(.MUTE_CYC(MUTE), .LAMP_CYC(40), .SIMUL_CYC(60)) u_mlg_guard_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_pins(pins), .o_motor_safety_one(s_one),
    .o_motor_safety_two(s_two), .o_test_pulse_a(pa), .o_test_pulse_b(pb),
    .o_muting_lamp(lamp), .o_motor_enable(en), .o_muting_active(act), .o_fault(fault));
  mlg_field_model u_mlg_field_model (.i_pulse_a(pa), .i_pulse_b(pb), .i_out_one(s_one),
    .i_out_two(s_two), .i_lamp(lamp), .i_beam(beam), .i_sensors(sens), .i_start(start),
    .i_cont(cont), .i_lamp_ok(lamp_ok), .i_mode(mode), .o_pins(pins));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // fresh reset, clear field, then a start press of random length
  task automatic restart(input logic [2:0] m);
    mode = m;
    beam = 1'b1;
    sens = 4'h0;
    lamp_ok = 1'b1;
    i_rst = 1'b1;
    cyc(16);
    i_rst = 1'b0;
    cyc(30);
    start = 1'b1;
    cyc(1 + $urandom % 4);
    start = 1'b0;
    cyc(6);
  endtask
  initial begin
    i_rst = 1'b1;
    start = 1'b0;
    cont = 1'b0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h63D2C525));
    restart(3'h0);
    chk("started", 5'({s_one, s_two, en}), 5'h07);
    beam = 1'b0;
    cyc(24);
    chk("guard broken", 5'({s_one, en}), 5'h00);
    restart(3'h0);
    sens = 4'hC;
    cyc(5);
    chk("lamp on", 5'({lamp, act}), 5'h03);
    beam = 1'b0;
    cyc(24);
    chk("muted run", 5'({s_one, en}), 5'h03);
    sens = 4'hF;
    cyc(4);
    sens = 4'h3;
    cyc(MUTE - 50);
    chk("still muting", 5'(act), 5'h01);
    cyc(30);
    chk("expired", 5'({act, en, s_one}), 5'h00);
    cont = 1'b1;
    cyc(5);
    cont = 1'b0;
    lamp_ok = 1'b0;
    chk("muting again", 5'({act, en}), 5'h03);
    cyc(20);
    chk("lamp blanked", fault, 5'h00);
    cyc(40);
    chk("lamp defect", 5'({fault.lamp_defect, en}), 5'h02);
    for (int m = 0; m < 7; m++) begin
      restart(m[2:0]);
      cyc(600);
      sens = 4'hC;
      cyc(10);
      chk("fault", fault, exp_fault[m][4:0]);
      chk("drive", 5'(s_one), 5'(m == 0));
    end
    complete_run();
  end
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
